// ---- fitp_top.sv ----
// Operation
// - flags individually input or output, readable conditions
// - flags are inputs after every reset
// - enabled asserted low request raises core interrupt
// - per-input edge or level detection select
// - requests disabled after reset unless boot strap
// - expiry output high exactly four clock cycles; with a timer period below 4 the pulses merge and the output stays high longer
// - expiry pin sampled as strap during reset
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
module fitp_top
   import fitp_pkg::*;
(
   input  wire logic                         ref_clk,          // system clock, 40 MHz
   input  wire logic                         rst,              // synchronous reset, active high
   // apb slave
   input  wire logic                         psel,             // slave select
   input  wire logic                         penable,          // access phase
   input  wire logic                         pwrite,           // 1 write, 0 read
   input  wire logic [fitp_pkg::ADDR_W-1:0]  paddr,            // byte address
   input  wire logic [fitp_pkg::DATA_W-1:0]  pwdata,           // write data
   output logic      [fitp_pkg::DATA_W-1:0]  prdata,           // read data
   output logic                              pready,           // always ready
   output logic                              pslverr,          // unmapped address
   // program flag pins
   input  wire logic [fitp_pkg::NUM_FLAGS-1:0] programFlagIn,  // pin level
   output logic      [fitp_pkg::NUM_FLAGS-1:0] programFlagOut, // driven level
   output logic      [fitp_pkg::NUM_FLAGS-1:0] programFlagOe,  // high while driving
   output logic      [fitp_pkg::NUM_FLAGS-1:0] programCond,    // conditions for the core
   // interrupt request inputs
   input  wire logic [fitp_pkg::NUM_IRQS-1:0]  irqReqInN,      // active low request pins
   input  wire logic [fitp_pkg::NUM_IRQS-1:0]  irqCoreAck,     // core takes the interrupt
   output logic      [fitp_pkg::NUM_IRQS-1:0]  irqCoreReq,     // interrupt to the core
   input  wire logic                           bootIrqStrap,   // boot strap pin selects irq boot
   // timer 0 expired pin
   input  wire logic                         timer0ExpIn,      // pin level, strap at reset
   output logic                              timer0ExpOut,     // expiry pulse
   output logic                              timer0ExpOe,      // high while driving
   // interrupt output
   output logic                              intReq            // unmasked status pending
);
   import fitp_pkg::*;

   // synchronised pins
   logic [NUM_FLAGS-1:0] flagSync;
   logic [NUM_IRQS-1:0]  irqSyncN;
   logic                 strapIrqSync;
   logic                 tmrPinSync;

   // control registers
   logic [NUM_FLAGS-1:0] flagDir;
   logic [NUM_FLAGS-1:0] flagOutReg;
   logic [NUM_IRQS-1:0]  irqEnable;
   logic [NUM_IRQS-1:0]  irqEdge;
   logic [31:0]          tmrPeriod;
   logic                 tmrEnable;
   logic [STAT_W-1:0]    intMask;
   logic [STAT_W-1:0]    intStatus;

   // strap state
   logic                 strapTmr;
   logic                 strapIrq;
   logic                 strapLoad;

   // timer state
   logic [31:0]          tmrCount;
   logic                 tmrExpire;
   logic [2:0]           pulseCount;

   // channel outputs
   logic [NUM_IRQS-1:0]  irqPending;
   logic [NUM_IRQS-1:0]  irqEvent;
   logic [NUM_IRQS-1:0]  irqAck;

   // flag change detection
   logic [NUM_FLAGS-1:0] flagLast;
   logic [NUM_FLAGS-1:0] flagChange;

   // bus decode
   logic                 setupPhase;
   logic                 accessWr;
   logic                 accessRd;
   logic                 addrHit;
   logic [DATA_W-1:0]    next_prdata;
   logic [STAT_W-1:0]    statSet;
   logic [STAT_W-1:0]    statClr;
   logic [NUM_IRQS-1:0]  pendClr;

   fitp_sync #(
      .WIDTH     (NUM_FLAGS),
      .RESET_VAL (4'h0)
   ) u_flag_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn (programFlagIn),
      .syncOut (flagSync)
   );

   fitp_sync #(
      .WIDTH     (NUM_IRQS),
      .RESET_VAL (4'hF)
   ) u_irq_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn (irqReqInN),
      .syncOut (irqSyncN)
   );

   // strap pin synchronisers
   fitp_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h0)
   ) u_strap_sync (
      .ref_clk (ref_clk),
      .rst     (1'b0),
      .asyncIn ({bootIrqStrap, timer0ExpIn}),
      .syncOut ({strapIrqSync, tmrPinSync})
   );

   // bus phase decode
   assign setupPhase = psel & ~penable;
   assign accessWr   = psel & penable & pwrite;
   assign accessRd   = psel & penable & ~pwrite;
   assign pready     = 1'b1;

   // address map check
   always_comb begin
      case (paddr)
         OFS_FLAG_DIR, OFS_FLAG_OUT, OFS_FLAG_IN, OFS_IRQ_CTRL, OFS_IRQ_PEND,
         OFS_STRAP, OFS_TMR_PERIOD, OFS_TMR_CTRL, OFS_INT_STAT, OFS_INT_MASK: begin
            addrHit = 1'b1;
         end
         default: begin
            addrHit = 1'b0;
         end
      endcase
   end

   // strap capture while reset is held
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strapTmr  <= tmrPinSync;
         strapIrq  <= strapIrqSync;
         strapLoad <= 1'b1;
      end else begin
         strapLoad <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flagDir <= RST_FLAG_DIR;
      end else if (accessWr && paddr == OFS_FLAG_DIR) begin
         flagDir <= pwdata[NUM_FLAGS-1:0];
      end
   end

   // flag output level register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flagOutReg <= RST_FLAG_OUT;
      end else if (accessWr && paddr == OFS_FLAG_OUT) begin
         flagOutReg <= pwdata[NUM_FLAGS-1:0];
      end
   end

   assign programFlagOe  = flagDir;
   assign programFlagOut = flagOutReg;
   assign programCond    = flagSync;

   // flag input change detection
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flagLast <= 4'h0;
      end else begin
         flagLast <= flagSync;
      end
   end
   assign flagChange = (flagSync ^ flagLast) & ~flagDir;

   // request enables, strap decides after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqEnable <= RST_IRQ_EN;
      end else if (strapLoad) begin
         irqEnable <= {NUM_IRQS{strapIrq}};
      end else if (accessWr && paddr == OFS_IRQ_CTRL) begin
         irqEnable <= pwdata[IRQ_EN_LSB +: NUM_IRQS];
      end
   end

   // edge or level select per input
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqEdge <= RST_IRQ_EDGE;
      end else if (accessWr && paddr == OFS_IRQ_CTRL) begin
         irqEdge <= pwdata[IRQ_EDGE_LSB +: NUM_IRQS];
      end
   end

   // software clears edge latches by writing ones
   assign pendClr = (accessWr && paddr == OFS_IRQ_PEND) ? pwdata[NUM_IRQS-1:0] : 4'h0;
   assign irqAck  = pendClr | irqCoreAck;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IRQS; gi++) begin : g_irq
         fitp_irq_chan u_chan (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .reqLevel (~irqSyncN[gi]),
            .enable   (irqEnable[gi]),
            .edgeMode (irqEdge[gi]),
            .ack      (irqAck[gi]),
            .pending  (irqPending[gi]),
            .reqEvent (irqEvent[gi])
         );
      end
   endgenerate

   assign irqCoreReq = irqPending;

   // timer period register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tmrPeriod <= RST_TMR_PERIOD;
      end else if (accessWr && paddr == OFS_TMR_PERIOD) begin
         tmrPeriod <= pwdata;
      end
   end

   // timer enable register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tmrEnable <= RST_TMR_EN;
      end else if (accessWr && paddr == OFS_TMR_CTRL) begin
         tmrEnable <= pwdata[TMR_EN_BIT];
      end
   end

   // timer 0 down counter, reloads on expiry
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tmrCount <= RST_TMR_PERIOD;
      end else if (!tmrEnable) begin
         tmrCount <= tmrPeriod;
      end else if (tmrCount == 32'h0000_0000) begin
         tmrCount <= tmrPeriod;
      end else begin
         tmrCount <= tmrCount - 32'h0000_0001;
      end
   end
   assign tmrExpire = tmrEnable && (tmrCount == 32'h0000_0000);

   // four cycle expiry pulse, restarts on expiry
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pulseCount <= 3'h0;
      end else if (tmrExpire) begin
         pulseCount <= TMR0_PULSE_CYCLES;
      end else if (pulseCount != 3'h0) begin
         pulseCount <= pulseCount - 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timer0ExpOut <= 1'b0;
      end else begin
         timer0ExpOut <= tmrExpire || (pulseCount > 3'h1);
      end
   end

   // pin released during reset, driven after
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timer0ExpOe <= 1'b0;
      end else begin
         timer0ExpOe <= 1'b1;
      end
   end

   // interrupt mask register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         intMask <= RST_INT_MASK;
      end else if (accessWr && paddr == OFS_INT_MASK) begin
         intMask <= pwdata[STAT_W-1:0];
      end
   end

   // sticky status, read clears, set wins
   always_comb begin
      statSet = '0;
      statSet[STAT_IRQ_LSB +: NUM_IRQS]   = irqEvent;
      statSet[STAT_TMR_BIT]               = tmrExpire;
      statSet[STAT_FLAG_LSB +: NUM_FLAGS] = flagChange;
      statClr = (accessRd && paddr == OFS_INT_STAT) ? {STAT_W{1'b1}} : '0;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         intStatus <= '0;
      end else begin
         intStatus <= (intStatus & ~statClr) | statSet;
      end
   end

   // level interrupt output
   assign intReq = |(intStatus & intMask);

   // read data mux, sampled in the setup cycle
   always_comb begin
      next_prdata = '0;
      case (paddr)
         OFS_FLAG_DIR: begin
            next_prdata[NUM_FLAGS-1:0] = flagDir;
         end
         OFS_FLAG_OUT: begin
            next_prdata[NUM_FLAGS-1:0] = flagOutReg;
         end
         OFS_FLAG_IN: begin
            next_prdata[NUM_FLAGS-1:0] = flagSync;
         end
         OFS_IRQ_CTRL: begin
            next_prdata[IRQ_EN_LSB +: NUM_IRQS]   = irqEnable;
            next_prdata[IRQ_EDGE_LSB +: NUM_IRQS] = irqEdge;
         end
         OFS_IRQ_PEND: begin
            next_prdata[NUM_IRQS-1:0] = irqPending;
         end
         OFS_STRAP: begin
            next_prdata[STRAP_TMR_BIT] = strapTmr;
            next_prdata[STRAP_IRQ_BIT] = strapIrq;
         end
         OFS_TMR_PERIOD: begin
            next_prdata = tmrPeriod;
         end
         OFS_TMR_CTRL: begin
            next_prdata[TMR_EN_BIT] = tmrEnable;
         end
         OFS_INT_STAT: begin
            next_prdata[STAT_W-1:0] = intStatus | statSet;
         end
         OFS_INT_MASK: begin
            next_prdata[STAT_W-1:0] = intMask;
         end
         default: begin
            next_prdata = '0;
         end
      endcase
   end

   // registered read data and error
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata  <= next_prdata;
         pslverr <= ~addrHit;
      end
   end
endmodule // fitp_top

// ---- fitp_pkg.sv ----
// shared constants for the flag, interrupt request and timer pin block
package fitp_pkg;

   // widths
   localparam int unsigned NUM_FLAGS = 4;
   localparam int unsigned NUM_IRQS  = 4;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned STAT_W    = 9;

   // register byte offsets
   localparam logic [7:0] OFS_FLAG_DIR   = 8'h00;
   localparam logic [7:0] OFS_FLAG_OUT   = 8'h04;
   localparam logic [7:0] OFS_FLAG_IN    = 8'h08;
   localparam logic [7:0] OFS_IRQ_CTRL   = 8'h0C;
   localparam logic [7:0] OFS_IRQ_PEND   = 8'h10;
   localparam logic [7:0] OFS_STRAP      = 8'h14;
   localparam logic [7:0] OFS_TMR_PERIOD = 8'h18;
   localparam logic [7:0] OFS_TMR_CTRL   = 8'h1C;
   localparam logic [7:0] OFS_INT_STAT   = 8'h20;
   localparam logic [7:0] OFS_INT_MASK   = 8'h24;

   // field positions
   localparam int unsigned IRQ_EN_LSB     = 0;
   localparam int unsigned IRQ_EDGE_LSB   = 4;
   localparam int unsigned STRAP_TMR_BIT  = 0;
   localparam int unsigned STRAP_IRQ_BIT  = 1;
   localparam int unsigned TMR_EN_BIT     = 0;
   localparam int unsigned STAT_IRQ_LSB   = 0;
   localparam int unsigned STAT_TMR_BIT   = 4;
   localparam int unsigned STAT_FLAG_LSB  = 5;

   // reset values
   localparam logic [3:0]  RST_FLAG_DIR   = 4'h0;
   localparam logic [3:0]  RST_FLAG_OUT   = 4'h0;
   localparam logic [3:0]  RST_IRQ_EN     = 4'h0;
   localparam logic [3:0]  RST_IRQ_EDGE   = 4'h0;
   localparam logic [31:0] RST_TMR_PERIOD = 32'h0000_0000;
   localparam logic        RST_TMR_EN     = 1'b0;
   localparam logic [8:0]  RST_INT_MASK   = 9'h000;

   // expiry pulse length in system clock cycles
   localparam logic [2:0]  TMR0_PULSE_CYCLES = 3'h4;

endpackage

// ---- fitp_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module fitp_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk, // system clock
   input  wire logic             rst,     // synchronous reset
   input  wire logic [WIDTH-1:0] asyncIn, // raw pin level
   output logic      [WIDTH-1:0] syncOut  // level on ref_clk
);
   logic [WIDTH-1:0] stage1;

   // first stage is read only by the second
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1  <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule // fitp_sync

// ---- fitp_irq_chan.sv ----
`timescale 1ns/10ps
// one interrupt request channel: edge or level detection
module fitp_irq_chan (
   input  wire logic ref_clk,  // system clock
   input  wire logic rst,      // synchronous reset
   input  wire logic reqLevel, // synced request, high when asserted
   input  wire logic enable,   // channel enabled
   input  wire logic edgeMode, // 1 edge, 0 level
   input  wire logic ack,      // core or software clears edge latch
   output logic      pending,  // request toward the core
   output logic      reqEvent  // one-cycle pulse on a new request
);
   logic reqLast;
   logic edgeLatch;
   logic newEdge;

   // assertion edge of the synced request
   assign newEdge = reqLevel & ~reqLast;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reqLast <= 1'b0;
      end else begin
         reqLast <= reqLevel;
      end
   end

   // edge latch, a new edge wins over the clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         edgeLatch <= 1'b0;
      end else if (!enable || !edgeMode) begin
         edgeLatch <= 1'b0;
      end else if (newEdge) begin
         edgeLatch <= 1'b1;
      end else if (ack) begin
         edgeLatch <= 1'b0;
      end
   end

   // request seen by the core
   assign pending = enable & (edgeMode ? edgeLatch : reqLevel);
   assign reqEvent = enable & newEdge;
endmodule // fitp_irq_chan

// ---- fitp_chk.sv ----
`timescale 1ns/10ps
// watches the pin block at its top ports
module fitp_chk
   import fitp_pkg::*;
(
   input wire logic        ref_clk,        // system clock
   input wire logic        rst,            // sync reset
   input wire logic        psel,           // apb select
   input wire logic        penable,        // apb access
   input wire logic        pwrite,         // apb direction
   input wire logic [7:0]  paddr,          // apb address
   input wire logic [31:0] pwdata,         // apb write data
   input wire logic        pslverr,        // apb error
   input wire logic [3:0]  programFlagIn,  // flag pin level
   input wire logic [3:0]  programFlagOut, // flag drive
   input wire logic [3:0]  programFlagOe,  // flag enable
   input wire logic [3:0]  programCond,    // flag conditions
   input wire logic [3:0]  irqCoreReq,     // core interrupts
   input wire logic        timer0ExpOut,   // expiry pulse
   input wire logic        timer0ExpOe     // expiry enable
);
   logic       apbWr;
   logic [3:0] wLow;
   // committed write and its low nibble
   assign apbWr = psel && penable && pwrite;
   assign wLow = pwdata[3:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_flag_rst_input: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> programFlagOe == 4'h0) else $error("flags driven after reset");
   a_irq_rst_quiet: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> irqCoreReq == 4'h0) else $error("core request during reset");
   a_exp_rst_strap: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> !timer0ExpOe && !timer0ExpOut) else $error("expiry pin driven in reset");
   a_exp_drive_after: assert property (!rst |=> timer0ExpOe)
      else $error("expiry pin not driven after reset");
   a_flag_dir_write: assert property (apbWr && paddr == OFS_FLAG_DIR |=> programFlagOe == $past(wLow))
      else $error("flag direction not taken");
   a_flag_out_hold: assert property (!(apbWr && paddr == OFS_FLAG_OUT) |=> $stable(programFlagOut))
      else $error("flag level moved without write");
   a_cond_two_ff: assert property (!$past(rst) && !$past(rst, 2) |->
      programCond == $past(programFlagIn, 2)) else $error("condition delay wrong");
   a_pulse_four: assert property ($rose(timer0ExpOut) |-> timer0ExpOut [*4] ##1 !timer0ExpOut)
      else $error("expiry pulse length wrong");
   a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > OFS_INT_MASK)) else $error("slave error wrong");
   // main scenarios reached
   c_pulse: cover property ($rose(timer0ExpOut));
   c_irq_all: cover property (irqCoreReq == 4'hF);
   c_err: cover property (penable && pslverr);
endmodule // fitp_chk

bind fitp_top fitp_chk u_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .programFlagIn, .programFlagOut, .programFlagOe, .programCond, .irqCoreReq, .timer0ExpOut, .timer0ExpOe);

// ---- fitp_board.sv ----
`timescale 1ns/10ps
// board side: pulls, strap resistor and drivers on the pins
module fitp_board (
   input wire logic [3:0] programFlagOut, // device flag drive
   input wire logic [3:0] programFlagOe,  // device flag enable
   input wire logic       timer0ExpOut,   // device expiry drive
   input wire logic       timer0ExpOe,    // device expiry enable
   input wire logic [3:0] boardFlagDrv,   // board drives flag
   input wire logic [3:0] boardFlagLvl,   // board flag level
   input wire logic [3:0] boardIrq,       // board requests
   input wire logic       strapLvl,       // strap resistor level
   output logic     [3:0] programFlagIn,  // resolved flag wire
   output logic     [3:0] irqReqInN,      // request pins
   output logic           timer0ExpIn     // resolved expiry wire
);
   // flag wires: device, else board, else pull-down
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         programFlagIn[i] = programFlagOe[i] ? programFlagOut[i] : (boardFlagDrv[i] & boardFlagLvl[i]);
      end
   end
   // released request pins sit high on pull-ups
   assign irqReqInN = ~boardIrq;
   // strap resistor shows while device is not driving
   assign timer0ExpIn = timer0ExpOe ? timer0ExpOut : strapLvl;
endmodule // fitp_board

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   import fitp_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} fitp_row_t;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        bootIrqStrap = 1'b0, strapLvl = 1'b1, pready, pslverr, er;
   logic        timer0ExpIn, timer0ExpOut, timer0ExpOe, intReq;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  programFlagIn, programFlagOut, programFlagOe, programCond, irqReqInN, irqCoreReq;
   logic [3:0]  irqCoreAck = 4'h0, boardFlagDrv = 4'h0, boardFlagLvl = 4'h0, boardIrq = 4'h0;
   int          fails = 0, checksDone = 0, m;
   fitp_row_t   rows [6] = '{'{OFS_FLAG_DIR, 32'h0000_00FF, 32'h0000_000F, 1'b0},
      '{OFS_FLAG_OUT, 32'hFFFF_FFF5, 32'h0000_0005, 1'b0}, '{OFS_TMR_PERIOD, 32'h1234_5678, 32'h1234_5678, 1'b0},
      '{OFS_INT_MASK, 32'hFFFF_FFFF, 32'h0000_01FF, 1'b0}, '{OFS_IRQ_CTRL, 32'h0000_00FF, 32'h0000_00FF, 1'b0},
      '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   fitp_top dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .programFlagIn, .programFlagOut, .programFlagOe, .programCond, .irqReqInN, .irqCoreAck, .irqCoreReq,
      .bootIrqStrap, .timer0ExpIn, .timer0ExpOut, .timer0ExpOe, .intReq);
   fitp_board brd (.programFlagOut, .programFlagOe, .timer0ExpOut, .timer0ExpOe, .boardFlagDrv,
      .boardFlagLvl, .boardIrq, .strapLvl, .programFlagIn, .irqReqInN, .timer0ExpIn);

   // compare and count
   task chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // ends once pready is high; only the watchdog ends it if pready stays low
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task doReset(input logic irqS, input logic tmrS);
      bootIrqStrap <= irqS; strapLvl <= tmrS; rst <= 1'b1;
      cyc(12);
      chk(programFlagOe, 4'h0);
      chk(timer0ExpOe, 1'b0);
      rst <= 1'b0;
      cyc(1);
   endtask
   task completeRun;
      if (fails == 0 && checksDone > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      cyc(4000);
      fails++;
      completeRun;
   end

   // main sequence
   initial begin
      doReset(1'b0, 1'b1);
      apb(1'b0, OFS_STRAP, 32'h0); chk(rd, 32'h0000_0001);
      apb(1'b0, OFS_IRQ_CTRL, 32'h0); chk(rd, 32'h0000_0000);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].r);
         chk(er, rows[i].e);
      end
      cyc(3);
      chk({programFlagOe, programFlagOut, programCond}, 12'hF55);
      // flags back to inputs, board drives them
      boardFlagDrv <= 4'hF; boardFlagLvl <= 4'hA;
      apb(1'b1, OFS_FLAG_DIR, 32'h0);
      cyc(3); chk(programCond, 4'hA);
      apb(1'b0, OFS_FLAG_IN, 32'h0); chk(rd, 32'h0000_000A);
      chk(intReq, 1'b1);
      apb(1'b1, OFS_INT_MASK, 32'h0); cyc(1); chk(intReq, 1'b0);
      apb(1'b1, OFS_INT_MASK, 32'h1FF); cyc(1); chk(intReq, 1'b1);
      apb(1'b0, OFS_INT_STAT, 32'h0); chk(rd, 32'h0000_01E0); cyc(1); chk(intReq, 1'b0);
      // channels 0 and 2 edge, 1 and 3 level
      apb(1'b1, OFS_IRQ_CTRL, 32'h0000_005F);
      boardIrq <= 4'hF; cyc(4); chk(irqCoreReq, 4'hF);
      boardIrq <= 4'h0; cyc(4); chk(irqCoreReq, 4'h5);
      // pending read, then clear channel 0 by software
      apb(1'b0, OFS_IRQ_PEND, 32'h0); chk(rd, 32'h0000_0005);
      apb(1'b1, OFS_IRQ_PEND, 32'h0000_0001); cyc(1); chk(irqCoreReq, 4'h4);
      irqCoreAck <= 4'hF; cyc(1); irqCoreAck <= 4'h0;
      cyc(1); chk(irqCoreReq, 4'h0);
      apb(1'b1, OFS_IRQ_CTRL, 32'h0000_00F0);
      boardIrq <= 4'hF; cyc(4); chk(irqCoreReq, 4'h0);
      boardIrq <= 4'h0;
      // timer expiry every ten cycles
      apb(1'b1, OFS_TMR_PERIOD, 32'h0000_0009);
      apb(1'b1, OFS_TMR_CTRL, 32'h0000_0001);
      m = 0;
      while (timer0ExpOut !== 1'b1 && m < 50) begin cyc(1); m++; end
      m = 0;
      while (timer0ExpOut === 1'b1 && m < 20) begin cyc(1); m++; end
      chk(m, 4);
      m = 0;
      while (timer0ExpOut !== 1'b1 && m < 50) begin cyc(1); m++; end
      chk(m, 6);
      apb(1'b1, OFS_TMR_CTRL, 32'h0);
      // reset again with irq boot strap
      doReset(1'b1, 1'b0);
      apb(1'b0, OFS_STRAP, 32'h0); chk(rd, 32'h0000_0002);
      apb(1'b0, OFS_IRQ_CTRL, 32'h0); chk(rd, 32'h0000_000F);
      boardIrq <= 4'h8; cyc(4); chk(irqCoreReq, 4'h8);
      completeRun;
   end
endmodule // tb_top
